// ===== qdr_burst4_sram.sv
// Burst-of-four SRAM with separate double-rate read and write ports.
// Assumes the link clock pair and all pins are asynchronous to sys_clk,
// which runs at least four times faster than the link clock.
//
// Notes on behaviour
// - Read and write data run concurrently; commands share one acceptance slot.
// - Every access is exactly four beats.
// - Any accepted command blocks the next true edge for both kinds.
// - Address and selects sampled on true edges.
// - Beats one and three captured on true edges.
// - Beats two and four captured on complementary edges.
// - Per-beat byte masks; masked bytes keep contents.
// - First write beat one cycle after command.
// - A write spans two full input cycles.
// - Read beats one, three on complementary edges.
// - Read beats two, four on true edges.
// - A read spans two full input cycles.
// - Echo strobes edge-aligned with read data.
// - All inputs and read outputs registered.
// - Output valid flag marks valid read data.
// - Address ignored when device is deselected.
// - Loop enable low selects short latency mode.
`timescale 1ns/1ps
module qdr_burst4_sram (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  // Link clock pair
  input  wire logic                            link_clk,
  input  wire logic                            link_clk_n,
  // Command inputs
  input  wire logic [qdr_sram_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                            read_sel_n,
  input  wire logic                            write_sel_n,
  input  wire logic                            loop_enable,
  // Write port
  input  wire logic [qdr_sram_pkg::DATA_W-1:0] write_bus,
  input  wire logic [qdr_sram_pkg::MASK_W-1:0] byte_write_mask_n,
  // Read port
  output logic [qdr_sram_pkg::DATA_W-1:0]      read_bus,
  output logic                                 output_valid_flag,
  output logic                                 echo_strobe_pos,
  output logic                                 echo_strobe_neg,
  // Status
  output logic                                 loop_locked
);

  localparam int AW  = qdr_sram_pkg::ADDR_W;
  localparam int DW  = qdr_sram_pkg::DATA_W;
  localparam int MW  = qdr_sram_pkg::MASK_W;
  localparam int WAW = qdr_sram_pkg::WORD_AW;
  localparam int SYNC_W = AW + DW + MW + 3;

  // ****************************************************************
  // Shared decode functions
  // ****************************************************************
  function automatic logic [WAW-1:0] word_idx(
    input logic [AW-1:0]                      addr,
    input logic [qdr_sram_pkg::BEAT_W-1:0]    beat
  );
    word_idx = {addr[qdr_sram_pkg::MEM_AW-1:0], beat};
  endfunction : word_idx

  // Bytes whose active-low mask bit is low take the new data.
  function automatic logic [DW-1:0] merge_bytes(
    input logic [DW-1:0] old_word,
    input logic [DW-1:0] new_word,
    input logic [MW-1:0] mask_n
  );
    logic [DW-1:0] res;
    res = old_word;
    for (int b = 0; b < MW; b++) begin
      if (!mask_n[b]) begin
        res[b*qdr_sram_pkg::BYTE_W +: qdr_sram_pkg::BYTE_W] =
          new_word[b*qdr_sram_pkg::BYTE_W +: qdr_sram_pkg::BYTE_W];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic              k_s1;
  logic              k_s2;
  logic              kn_s1;
  logic              kn_s2;
  logic [SYNC_W-1:0] pins_s1;
  logic [SYNC_W-1:0] pins_s2;

  // Every pin passes two flops; the first stage feeds only the second.
  always_ff @(posedge sys_clk) begin
    k_s1    <= link_clk;
    k_s2    <= k_s1;
    kn_s1   <= link_clk_n;
    kn_s2   <= kn_s1;
    pins_s1 <= {addr_in, read_sel_n, write_sel_n, loop_enable,
                write_bus, byte_write_mask_n};
    pins_s2 <= pins_s1;
  end

  logic [AW-1:0] addr_s;
  logic          rd_n_s;
  logic          wr_n_s;
  logic          loop_en_s;
  logic [DW-1:0] wdata_s;
  logic [MW-1:0] mask_s;

  assign {addr_s, rd_n_s, wr_n_s, loop_en_s, wdata_s, mask_s} = pins_s2;

  // ****************************************************************
  // Link edge detection and echo strobes
  // ****************************************************************
  logic echo_pos_q;
  logic echo_neg_q;
  logic k_rise;
  logic kn_rise;
  logic edge_any;

  // The echo flops double as the edge detector's history, so each echo
  // edge lands on the very sys_clk edge that updates the read data.
  assign k_rise   = k_s2 && !echo_pos_q;
  assign kn_rise  = kn_s2 && !echo_neg_q;
  assign edge_any = k_rise || kn_rise;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      echo_pos_q <= qdr_sram_pkg::ECHO_RST;
      echo_neg_q <= qdr_sram_pkg::ECHO_RST;
    end else begin
      echo_pos_q <= k_s2;
      echo_neg_q <= kn_s2;
    end
  end

  assign echo_strobe_pos = echo_pos_q;
  assign echo_strobe_neg = echo_neg_q;

  // ****************************************************************
  // Delay-locked loop model
  // ****************************************************************
  logic [qdr_sram_pkg::LOCK_W-1:0] lock_cnt_q;
  logic                            locked;
  logic [3:0]                      rd_lat;

  localparam logic [qdr_sram_pkg::LOCK_W-1:0] LOCK_DONE =
    qdr_sram_pkg::LOCK_W'(qdr_sram_pkg::LOCK_CYCLES);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_cnt_q <= qdr_sram_pkg::LOCK_RST;
    end else if (!loop_en_s) begin
      lock_cnt_q <= qdr_sram_pkg::LOCK_RST;
    end else if (k_rise && lock_cnt_q != LOCK_DONE) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // Until lock is reached the short bypass latency stays in force. A
  // latency change while a read is in flight corrupts that one read.
  assign locked      = (lock_cnt_q == LOCK_DONE);
  assign loop_locked = locked;
  assign rd_lat = locked ? 4'(qdr_sram_pkg::RD_LAT_DLL)
                         : 4'(qdr_sram_pkg::RD_LAT_BYPASS);

  // ****************************************************************
  // Command acceptance
  // ****************************************************************
  logic          rd_v_q [qdr_sram_pkg::RD_PIPE_LEN];
  logic [AW-1:0] rd_a_q [qdr_sram_pkg::RD_PIPE_LEN];
  logic          wr_v_q [qdr_sram_pkg::WR_PIPE_LEN];
  logic [AW-1:0] wr_a_q [qdr_sram_pkg::WR_PIPE_LEN];
  logic          cmd_free;
  logic          rd_take;
  logic          wr_take;

  // An edge that follows an accepted command of either kind takes none,
  // so commands of either kind are taken at most on every other true edge.
  assign cmd_free = !(rd_v_q[qdr_sram_pkg::CMD_BUSY_POS] ||
                      wr_v_q[qdr_sram_pkg::CMD_BUSY_POS]);
  assign rd_take  = k_rise && cmd_free && !rd_n_s;
  assign wr_take  = k_rise && cmd_free && rd_n_s && !wr_n_s;

  // ****************************************************************
  // Half-cycle pipelines
  // ****************************************************************
  // Position n holds a command n link edges (either phase) old.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < qdr_sram_pkg::RD_PIPE_LEN; i++) begin
        rd_v_q[i] <= 1'b0;
      end
      for (int i = 0; i < qdr_sram_pkg::WR_PIPE_LEN; i++) begin
        wr_v_q[i] <= 1'b0;
      end
    end else if (edge_any) begin
      rd_v_q[0] <= rd_take;
      wr_v_q[0] <= wr_take;
      for (int i = 1; i < qdr_sram_pkg::RD_PIPE_LEN; i++) begin
        rd_v_q[i] <= rd_v_q[i-1];
      end
      for (int i = 1; i < qdr_sram_pkg::WR_PIPE_LEN; i++) begin
        wr_v_q[i] <= wr_v_q[i-1];
      end
    end
  end

  // Addresses load only with an accepted command.
  always_ff @(posedge sys_clk) begin
    if (edge_any) begin
      if (rd_take) begin
        rd_a_q[0] <= addr_s;
      end
      if (wr_take) begin
        wr_a_q[0] <= addr_s;
      end
      for (int i = 1; i < qdr_sram_pkg::RD_PIPE_LEN; i++) begin
        rd_a_q[i] <= rd_a_q[i-1];
      end
      for (int i = 1; i < qdr_sram_pkg::WR_PIPE_LEN; i++) begin
        wr_a_q[i] <= wr_a_q[i-1];
      end
    end
  end

  // ****************************************************************
  // Write beat capture
  // ****************************************************************
  logic                               wr_hit;
  logic [qdr_sram_pkg::BEAT_W-1:0]    wr_beat;
  logic [AW-1:0]                      wr_addr;

  // Beat b is taken at position WR_FIRST_POS + b: a true edge for beats
  // one and three, a complementary edge for beats two and four.
  always_comb begin
    wr_hit  = 1'b0;
    wr_beat = '0;
    wr_addr = '0;
    for (int i = 0; i < qdr_sram_pkg::BURST_LEN; i++) begin
      if (wr_v_q[qdr_sram_pkg::WR_FIRST_POS + i]) begin
        wr_hit  = 1'b1;
        wr_beat = qdr_sram_pkg::BEAT_W'(i);
        wr_addr = wr_a_q[qdr_sram_pkg::WR_FIRST_POS + i];
      end
    end
  end

  logic                             stage_v_q;
  logic [qdr_sram_pkg::ENTRY_W-1:0] stage_d_q;
  logic                             fifo_in_ready;

  // The stage holds its beat until the FIFO takes it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage_v_q <= 1'b0;
    end else if (edge_any && wr_hit) begin
      stage_v_q <= 1'b1;
    end else if (fifo_in_ready) begin
      stage_v_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (edge_any && wr_hit) begin
      stage_d_q <= {word_idx(wr_addr, wr_beat), mask_s, wdata_s};
    end
  end

  // ****************************************************************
  // Write buffer and storage
  // ****************************************************************
  logic                             fifo_out_valid;
  logic                             fifo_out_ready;
  logic [qdr_sram_pkg::ENTRY_W-1:0] fifo_out_data;
  logic [WAW-1:0]                   head_idx;
  logic [MW-1:0]                    head_mask;
  logic [DW-1:0]                    head_data;
  logic                             rd_launch;

  sync_fifo #(
    .WIDTH (qdr_sram_pkg::ENTRY_W),
    .DEPTH (qdr_sram_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (stage_v_q),
    .in_ready  (fifo_in_ready),
    .in_data   (stage_d_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign {head_idx, head_mask, head_data} = fifo_out_data;

  // The array has one port, so a read launch stalls the drain; the held
  // head is forwarded into the read instead.
  assign fifo_out_ready = !rd_launch;

  logic [DW-1:0] mem [qdr_sram_pkg::MEM_WORDS];

  always_ff @(posedge sys_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      mem[head_idx] <= merge_bytes(mem[head_idx], head_data,
                                   head_mask);
    end
  end

  // ****************************************************************
  // Read beat launch
  // ****************************************************************
  logic                            rd_hit;
  logic [qdr_sram_pkg::BEAT_W-1:0] rd_beat;
  logic [AW-1:0]                   rd_addr;
  logic [WAW-1:0]                  rd_idx;
  logic [DW-1:0]                   rd_word;

  // Beat b leaves on the edge that moves its command to rd_lat + b.
  always_comb begin
    rd_hit  = 1'b0;
    rd_beat = '0;
    rd_addr = '0;
    for (int i = 0; i < qdr_sram_pkg::RD_PIPE_LEN; i++) begin
      if (rd_v_q[i] && (i + 1 >= int'(rd_lat)) &&
          (i + 1 < int'(rd_lat) + qdr_sram_pkg::BURST_LEN)) begin
        rd_hit  = 1'b1;
        rd_beat = qdr_sram_pkg::BEAT_W'(i + 1 - int'(rd_lat));
        rd_addr = rd_a_q[i];
      end
    end
  end

  assign rd_launch = edge_any && rd_hit;
  assign rd_idx    = word_idx(rd_addr, rd_beat);
  assign rd_word   = (fifo_out_valid && head_idx == rd_idx)
                   ? merge_bytes(mem[rd_idx], head_data, head_mask)
                   : mem[rd_idx];

  // ****************************************************************
  // Read outputs
  // ****************************************************************
  logic [DW-1:0] read_bus_q;
  logic          valid_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      read_bus_q <= qdr_sram_pkg::READ_BUS_RST;
    end else if (rd_launch) begin
      read_bus_q <= rd_word;
    end
  end

  // The flag changes only on link edges, so it moves with the echoes.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      valid_q <= qdr_sram_pkg::VALID_RST;
    end else if (edge_any) begin
      valid_q <= rd_hit;
    end
  end

  assign read_bus          = read_bus_q;
  assign output_valid_flag = valid_q;

endmodule : qdr_burst4_sram

// ===== qdr_sram_pkg.sv
// Constants shared by the burst-of-four SRAM model, its monitor and its bench.
// Assumes one system clock that oversamples the link clock pair.
package qdr_sram_pkg;

  // ****************************************************************
  // Port widths
  // ****************************************************************
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 36;
  localparam int MASK_W    = 4;
  localparam int BYTE_W    = 9;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W    = 2;

  // ****************************************************************
  // Storage actually modelled
  // ****************************************************************
  localparam int MEM_AW    = 6;
  localparam int WORD_AW   = MEM_AW + BEAT_W;
  localparam int MEM_WORDS = 1 << WORD_AW;

  // ****************************************************************
  // Pipeline positions, counted in link half-cycle edges
  // ****************************************************************
  localparam int RD_LAT_DLL    = 5;
  localparam int RD_LAT_BYPASS = 3;
  localparam int RD_PIPE_LEN   = 8;
  localparam int WR_FIRST_POS  = 1;
  localparam int WR_PIPE_LEN   = 5;
  localparam int CMD_BUSY_POS  = 1;

  // ****************************************************************
  // Loop lock and buffering
  // ****************************************************************
  localparam int LOCK_CYCLES = 64;
  localparam int LOCK_W      = 7;
  localparam int FIFO_DEPTH  = 32;
  localparam int ENTRY_W     = WORD_AW + MASK_W + DATA_W;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] READ_BUS_RST = 36'h0_0000_0000;
  localparam logic              ECHO_RST     = 1'b0;
  localparam logic              VALID_RST    = 1'b0;
  localparam logic [LOCK_W-1:0] LOCK_RST     = 7'h00;

endpackage : qdr_sram_pkg

// ===== sync_fifo.sv
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data  = store[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : sync_fifo

// ===== qdr_burst4_sram_monitor.sv
// Port checks for the burst-of-four SRAM, bound to its top module.
// Assumes sys_clk runs eight times the link clock and that the pins
// stay quiet for two sys_clk cycles either side of each link edge.
`timescale 1ns/1ps
module qdr_burst4_sram_monitor (
  // Clock and reset
  input wire logic                            sys_clk,
  input wire logic                            rst_n,
  // Link side
  input wire logic                            link_clk,
  input wire logic                            link_clk_n,
  input wire logic [qdr_sram_pkg::ADDR_W-1:0] addr_in,
  input wire logic                            read_sel_n,
  input wire logic                            write_sel_n,
  input wire logic                            loop_enable,
  input wire logic [qdr_sram_pkg::DATA_W-1:0] write_bus,
  input wire logic [qdr_sram_pkg::MASK_W-1:0] byte_write_mask_n,
  // Read side and status
  input wire logic [qdr_sram_pkg::DATA_W-1:0] read_bus,
  input wire logic                            output_valid_flag,
  input wire logic                            echo_strobe_pos,
  input wire logic                            echo_strobe_neg,
  input wire logic                            loop_locked
);
  logic       lk_q;
  logic       took_q;
  logic [5:0] rd_age_q;
  logic [9:0] en_cnt_q;
  logic [2:0] up_q;
  logic       t_rise;
  logic       rd_take;
  assign t_rise  = link_clk && !lk_q;
  assign rd_take = t_rise && !read_sel_n && !took_q;

  // ****************************************************************
  // Helper state
  // ****************************************************************
  // The tracker mirrors the every-other-edge acceptance so that a
  // refused command never arms a latency check.
  always_ff @(posedge sys_clk) begin
    lk_q <= link_clk;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) took_q <= 1'b0;
    else if (t_rise) took_q <= (!read_sel_n || !write_sel_n) && !took_q;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) rd_age_q <= 6'h3f;
    else if (rd_take) rd_age_q <= 6'h00;
    else if (rd_age_q != 6'h3f) rd_age_q <= rd_age_q + 6'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !loop_enable) en_cnt_q <= 10'h000;
    else if (en_cnt_q != 10'h3ff) en_cnt_q <= en_cnt_q + 10'h001;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_lock_latency:
    assert property (rd_take && loop_locked |-> ##[20:26]
      ($rose(output_valid_flag) && $rose(echo_strobe_neg)))
    else $error("first read beat off the locked latency");
  a_bypass_latency:
    assert property (rd_take && !loop_enable |-> ##[12:18]
      ($rose(output_valid_flag) && $rose(echo_strobe_neg)))
    else $error("first read beat off the bypass latency");
  a_lock_drops:
    assert property ((!loop_enable)[*6] |-> !loop_locked)
    else $error("loop still locked while bypassed");
  a_lock_not_early:
    assert property ($rose(loop_locked) |-> en_cnt_q >= 10'h1e0)
    else $error("loop locked too soon");
  a_bus_on_echo:
    assert property ($changed(read_bus) |->
      ($rose(echo_strobe_pos) || $rose(echo_strobe_neg)))
    else $error("read bus moved without an echo edge");
  a_valid_on_echo:
    assert property ($changed(output_valid_flag) |->
      ($rose(echo_strobe_pos) || $rose(echo_strobe_neg)))
    else $error("valid flag moved without an echo edge");
  a_echo_follows:
    assert property ($rose(link_clk) |-> ##[1:5] $rose(echo_strobe_pos))
    else $error("echo strobe missed a link edge");
  a_echo_pair_opposite:
    assert property (up_q == 3'h7 |-> echo_strobe_pos != echo_strobe_neg)
    else $error("echo strobes not complementary");
  a_valid_has_cause:
    assert property ($rose(output_valid_flag) |->
      rd_age_q inside {[6'h0c:6'h1a]})
    else $error("read data without an accepted read");

  c_locked_read: cover property (rd_take && loop_locked);
  c_bypass_read: cover property (rd_take && !loop_enable);
  c_write_taken: cover property (t_rise && !write_sel_n && read_sel_n);
endmodule : qdr_burst4_sram_monitor

bind qdr_burst4_sram qdr_burst4_sram_monitor u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
  .link_clk_n(link_clk_n), .addr_in(addr_in), .read_sel_n(read_sel_n),
  .write_sel_n(write_sel_n), .loop_enable(loop_enable),
  .write_bus(write_bus), .byte_write_mask_n(byte_write_mask_n),
  .read_bus(read_bus), .output_valid_flag(output_valid_flag),
  .echo_strobe_pos(echo_strobe_pos), .echo_strobe_neg(echo_strobe_neg),
  .loop_locked(loop_locked));

// ===== qdr_ctrl_model.sv
// Memory controller model: free-running link clock pair, commands
// and write beats. Assumes the bench spaces commands legally.
`timescale 1ns/1ps
module qdr_ctrl_model (
  // Link clock pair
  output logic                            link_clk,
  output logic                            link_clk_n,
  // Commands
  output logic [qdr_sram_pkg::ADDR_W-1:0] addr_in,
  output logic                            read_sel_n,
  output logic                            write_sel_n,
  // Write port
  output logic [qdr_sram_pkg::DATA_W-1:0] write_bus,
  output logic [qdr_sram_pkg::MASK_W-1:0] byte_write_mask_n
);
  assign link_clk_n = ~link_clk;

  // The odd start offset keeps link edges off the sys_clk grid.
  initial begin
    link_clk = 1'b0;
    addr_in = '0;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    write_bus = '0;
    byte_write_mask_n = 4'hf;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // Pins change midway between link edges; a released address is
  // inverted so a stale value can never pass for a held one.
  task automatic issue(input logic rd,
                       input logic [qdr_sram_pkg::ADDR_W-1:0] a,
                       input int skip);
    repeat (skip) @(posedge link_clk);
    @(negedge link_clk);
    #40;
    addr_in = a;
    if (rd) read_sel_n = 1'b0;
    else write_sel_n = 1'b0;
    #80;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr_in = ~a;
  endtask : issue

  task automatic write_burst(input logic [qdr_sram_pkg::ADDR_W-1:0] a,
                             input logic [3:0][35:0] d,
                             input logic [15:0] m, input int skip);
    issue(1'b0, a, skip);
    for (int b = 0; b < 4; b++) begin
      #80;
      write_bus = d[b];
      byte_write_mask_n = m[4*b +: 4];
    end
    #80;
    write_bus = ~write_bus;
    byte_write_mask_n = ~byte_write_mask_n;
  endtask : write_burst
endmodule : qdr_ctrl_model

// ===== test_qdr_burst4_sram.sv
// Self-checking bench for the burst-of-four SRAM with a controller
// model on the link side. Expected data comes from a shadow memory.
`timescale 1ns/1ps
module test_qdr_burst4_sram;
  typedef struct {
    logic [19:0] wa;
    logic [15:0] m;
    logic        rd_first;
    logic [19:0] ra;
  } row_t;
  logic                            sys_clk, rst_n, loop_enable;
  logic                            link_clk, link_clk_n;
  logic                            read_sel_n, write_sel_n;
  logic [qdr_sram_pkg::ADDR_W-1:0] addr_in;
  logic [qdr_sram_pkg::DATA_W-1:0] write_bus, read_bus;
  logic [qdr_sram_pkg::MASK_W-1:0] byte_write_mask_n;
  logic                            output_valid_flag, loop_locked;
  logic                            echo_strobe_pos, echo_strobe_neg;
  logic                            ep_q, en_q;
  logic [35:0]                     shadow [256];
  logic [35:0]                     beats [$];
  row_t                            rows [6];
  int                              err_total, samples_checked;

  qdr_burst4_sram u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_clk_n(link_clk_n), .addr_in(addr_in), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .loop_enable(loop_enable),
    .write_bus(write_bus), .byte_write_mask_n(byte_write_mask_n),
    .read_bus(read_bus), .output_valid_flag(output_valid_flag),
    .echo_strobe_pos(echo_strobe_pos), .echo_strobe_neg(echo_strobe_neg),
    .loop_locked(loop_locked));
  qdr_ctrl_model u_ctrl (
    .link_clk(link_clk), .link_clk_n(link_clk_n), .addr_in(addr_in),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
    .write_bus(write_bus), .byte_write_mask_n(byte_write_mask_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // A beat is taken at each echo rise while the valid flag is high.
  always @(negedge sys_clk) begin
    if (output_valid_flag === 1'b1 &&
        ((echo_strobe_pos && !ep_q) || (echo_strobe_neg && !en_q)))
      beats.push_back(read_bus);
    ep_q <= echo_strobe_pos;
    en_q <= echo_strobe_neg;
  end

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [35:0] exp,
                     input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_lock();
    for (int n = 0; n < 2000 && loop_locked !== 1'b1; n++) @(posedge sys_clk);
    chk("loop locked", 36'h1, {35'h0, loop_locked});
  endtask : wait_lock

  task automatic take_beats(input logic [5:0] ra);
    for (int n = 0; n < 300 && beats.size() < 4; n++) @(posedge sys_clk);
    if (beats.size() < 4) begin
      chk("beat count", 36'h4, 36'(beats.size()));
      report_and_stop();
    end
    repeat (40) @(posedge sys_clk);
    chk("beat count", 36'h4, 36'(beats.size()));
    for (int b = 0; b < 4; b++)
      chk("read beat", shadow[{ra, 2'(b)}], beats[b]);
  endtask : take_beats

  task automatic run_row(input row_t r, input int idx);
    logic [3:0][35:0] d;
    for (int b = 0; b < 4; b++) begin
      d[b] = {4'(idx), 4'(b), 28'h5c3a96e};
      for (int k = 0; k < 4; k++)
        if (!r.m[4*b+k]) shadow[{r.wa[5:0], 2'(b)}][9*k +: 9] = d[b][9*k +: 9];
    end
    beats.delete();
    fork
      if (r.rd_first) u_ctrl.issue(1'b1, r.ra, 0);
      else begin
        @(negedge write_sel_n);
        u_ctrl.issue(1'b1, r.ra, 2);
      end
      if (!r.rd_first) u_ctrl.write_burst(r.wa, d, r.m, 0);
      else begin
        @(negedge read_sel_n);
        u_ctrl.write_burst(r.wa, d, r.m, 2);
      end
    join
    take_beats(r.ra[5:0]);
  endtask : run_row

  initial begin
    rst_n = 1'b0;
    loop_enable = 1'b1;
    err_total = 0;
    samples_checked = 0;
    rows = '{'{20'h00001, 16'h0000, 1'b0, 20'h00001},
             '{20'h00001, 16'hc3a5, 1'b0, 20'h00001},
             '{20'h0003f, 16'h0000, 1'b0, 20'h0003f},
             '{20'hfffff, 16'hffff, 1'b0, 20'h0003f},
             '{20'h00010, 16'h0000, 1'b1, 20'h0003f},
             '{20'hc0010, 16'h7ebd, 1'b0, 20'h00010}};
    repeat (2) @(posedge sys_clk);
    #1;
    chk("reset read bus", 36'h0, read_bus);
    chk("reset flags", 36'h0, {32'h0, output_valid_flag, echo_strobe_pos,
                               echo_strobe_neg, loop_locked});
    rst_n = 1'b1;
    wait_lock();
    for (int i = 0; i < 6; i++) run_row(rows[i], i);
    // A read on the edge right after an accepted one must be ignored.
    beats.delete();
    u_ctrl.issue(1'b1, 20'h00001, 0);
    u_ctrl.issue(1'b1, 20'h0003f, 0);
    take_beats(6'h01);
    @(posedge sys_clk);
    #1 loop_enable = 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("bypass lock", 36'h0, {35'h0, loop_locked});
    beats.delete();
    u_ctrl.issue(1'b1, 20'h00010, 0);
    take_beats(6'h10);
    @(posedge sys_clk);
    #1 loop_enable = 1'b1;
    wait_lock();
    report_and_stop();
  end
endmodule : test_qdr_burst4_sram
